/* File: gcsd_top.sv */
`include "gcsd_regs.svh"
module gcsd_top #(
  parameter logic [35:0] SD_UNIT_CYC = 36'(`GCSD_SD_UNIT_CYC)
) (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic [6:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  input  wire logic        gpio_pin,
  input  wire logic        charging,
  input  wire logic signed [7:0] temp_c,
  input  wire logic [12:0] batt_mv,
  input  wire logic [15:0] chg_sense_uv,
  input  wire logic [15:0] nominal_available_capacity,
  output logic      [15:0] activity_filter_uv,
  output logic      [12:0] term_mv,
  output logic             full_charge,
  output logic      [7:0]  rate_comp_constants,
  output logic      [7:0]  temp_comp_constants,
  output logic             pin_input_en,
  output logic             sd_step,
  output logic      [15:0] sd_amount
);
  ////////////////////////////////////////////////////////////////////////////
  // storage
  logic [7:0] nvm_q [`GCSD_NVM_LO:`GCSD_NVM_HI];
  logic [7:0] mem_en_q;
  logic       init_q;
  logic       pin_s1_q;
  logic       pin_s2_q;
  logic       pin_level_flag_q;
  logic       wr_nvm;
  logic       in_nvm;
  logic [7:0] fsd_b;
  logic [7:0] taper_b;
  logic [7:0] pack_b;
  logic [3:0] activity_filter_threshold;
  logic [3:0] self_discharge_code;
  logic       fixed_rate_comp;
  logic       fixed_temp_comp;
  logic       term_voltage_sel_hi;
  logic       term_voltage_sel_lo;
  logic [15:0] taper_uv;
  gcsd_pkg::gcsd_scale_t scale_d;
  gcsd_pkg::gcsd_scale_t scale_q;
  logic [7:0]  mode_b;

  gcsd_sd_if sd_if ();

  assign in_nvm = (reg_addr >= `GCSD_NVM_LO) && (reg_addr <= `GCSD_NVM_HI);
  assign wr_nvm = reg_wr && in_nvm && (mem_en_q == `GCSD_MEMEN_KEY);

  assign fsd_b   = nvm_q[`GCSD_FSD_OFS];
  assign taper_b = nvm_q[`GCSD_TAPER_OFS];
  assign pack_b  = nvm_q[`GCSD_PACK_OFS];

  assign activity_filter_threshold = fsd_b[7:4];
  assign self_discharge_code       = fsd_b[3:0];
  assign term_voltage_sel_hi       = pack_b[`GCSD_PK_VHI_BIT];
  assign term_voltage_sel_lo       = pack_b[`GCSD_PK_VLO_BIT];
  assign fixed_rate_comp           = pack_b[`GCSD_PK_RFIX_BIT];
  assign fixed_temp_comp           = pack_b[`GCSD_PK_TFIX_BIT];
  assign taper_uv                  = 16'(taper_b) * `GCSD_TAPER_UV;

  assign mode_b = {6'h0, pin_level_flag_q, pin_input_en};

  ////////////////////////////////////////////////////////////////////////////
  // non-volatile bytes: no reset, contents survive resets
  always_ff @(posedge clk) begin
    if (wr_nvm) begin
      if (reg_addr == `GCSD_PACK_OFS) begin
        nvm_q[reg_addr] <= reg_wdata & `GCSD_PACK_MASK;
      end else begin
        nvm_q[reg_addr] <= reg_wdata;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mem_en_q <= 8'h00;
    end else if (reg_wr && reg_addr == `GCSD_MEMEN_OFS) begin
      mem_en_q <= reg_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register read path
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      if (in_nvm) begin
        reg_rdata <= nvm_q[reg_addr];
      end else if (reg_addr == `GCSD_MEMEN_OFS) begin
        reg_rdata <= mem_en_q;
      end else if (reg_addr == `GCSD_MODE_OFS) begin
        reg_rdata <= mode_b;
      end else begin
        reg_rdata <= 8'h00;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // general-purpose pin
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      init_q <= 1'b1;
    end else begin
      init_q <= 1'b0;
    end
  end

  // live enable is loaded from the stored setting at the first edge after reset
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_input_en <= 1'b0;
    end else if (init_q) begin
      pin_input_en <= pack_b[`GCSD_PK_PIN_BIT];
    end else if (reg_wr && reg_addr == `GCSD_MODE_OFS) begin
      pin_input_en <= reg_wdata[`GCSD_MODE_EN_BIT];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_s1_q <= 1'b0;
      pin_s2_q <= 1'b0;
    end else begin
      pin_s1_q <= gpio_pin;
      pin_s2_q <= pin_s1_q;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_level_flag_q <= 1'b0;
    end else begin
      pin_level_flag_q <= pin_input_en & pin_s2_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration outputs
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      activity_filter_uv <= 16'h0000;
    end else begin
      activity_filter_uv <= 16'(activity_filter_threshold) * `GCSD_DMF_UV;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      term_mv <= `GCSD_VT0_MV;
    end else begin
      unique case ({term_voltage_sel_hi, term_voltage_sel_lo})
        2'b00: term_mv <= `GCSD_VT0_MV;
        2'b01: term_mv <= `GCSD_VT1_MV;
        2'b10: term_mv <= `GCSD_VT2_MV;
        2'b11: term_mv <= `GCSD_VT3_MV;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rate_comp_constants <= `GCSD_FIX_RCOMP;
      temp_comp_constants <= `GCSD_FIX_TEMP_COMP_CONSTANTS;
    end else begin
      rate_comp_constants <= fixed_rate_comp ? `GCSD_FIX_RCOMP : nvm_q[`GCSD_RCOMP_OFS];
      temp_comp_constants <= fixed_temp_comp ? `GCSD_FIX_TEMP_COMP_CONSTANTS : nvm_q[`GCSD_TEMP_COMP_CONSTANTS_OFS];
    end
  end

  // full once voltage reaches the limit and charge current tapers to or below setting
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      full_charge <= 1'b0;
    end else begin
      full_charge <= charging && (batt_mv >= term_mv) && (chg_sense_uv <= taper_uv);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // temperature scaling of the self-discharge rate
  always_comb begin
    if (temp_c < 8'sd0 + `GCSD_T_BAND) begin
      scale_d = 3'd0;
    end else if (temp_c < 8'sd2 * `GCSD_T_BAND) begin
      scale_d = 3'd1;
    end else if (temp_c < 8'sd3 * `GCSD_T_BAND) begin
      scale_d = 3'd2;
    end else if (temp_c < 8'sd4 * `GCSD_T_BAND) begin
      scale_d = 3'd3;
    end else if (temp_c < 8'sd5 * `GCSD_T_BAND) begin
      scale_d = 3'd4;
    end else if (temp_c < 8'sd6 * `GCSD_T_BAND) begin
      scale_d = 3'd5;
    end else begin
      scale_d = 3'd6;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      scale_q <= 3'd2;
    end else begin
      scale_q <= scale_d;
    end
  end

  assign sd_if.code     = self_discharge_code;
  assign sd_if.scale    = scale_q;
  assign sd_if.charging = charging;

  gcsd_sd_timer #(
    .UNIT_CYC (SD_UNIT_CYC)
  ) u_timer (
    .clk   (clk),
    .rst_b (rst_b),
    .sd    (sd_if.est)
  );

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sd_step   <= 1'b0;
      sd_amount <= 16'h0000;
    end else begin
      sd_step   <= sd_if.step;
      sd_amount <= {9'h000, nominal_available_capacity[15:9]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_key_missing;
    reg_wr && in_nvm && mem_en_q != `GCSD_MEMEN_KEY;
  endsequence

  sequence s_reset_release;
    init_q;
  endsequence

  sequence s_step_seen;
    sd_if.step;
  endsequence

  AST_DMF_SCALE: assert property (@(posedge clk) disable iff (!rst_b)
    fsd_b[7:4] == $past(fsd_b[7:4]) |=> activity_filter_uv == 16'($past(fsd_b[7:4])) * 16'd6)
    else $error("filter threshold not six uV per count");

  AST_NOCHG_NO_STEP: assert property (@(posedge clk) disable iff (!rst_b)
    charging [*3] |-> !sd_step)
    else $error("self-discharge step while charging");

  AST_SCALE_REF: assert property (@(posedge clk) disable iff (!rst_b)
    (temp_c >= 8'sd20 && temp_c < 8'sd30) |=> scale_q == 3'd2)
    else $error("reference band not at programmed rate");

  AST_SCALE_HOT: assert property (@(posedge clk) disable iff (!rst_b)
    (temp_c >= 8'sd60) |=> scale_q == 3'd6)
    else $error("hot band not saturated at sixteen times");

  AST_SCALE_40: assert property (@(posedge clk) disable iff (!rst_b)
    (temp_c >= 8'sd40 && temp_c < 8'sd50) |=> scale_q == 3'd4)
    else $error("40 C band not four times");

  AST_SCALE_COLD: assert property (@(posedge clk) disable iff (!rst_b)
    (temp_c < 8'sd10) |=> scale_q == 3'd0)
    else $error("cold band not limited at one quarter");

  AST_STEP_AMOUNT: assert property (@(posedge clk) disable iff (!rst_b)
    s_step_seen |=> sd_step && sd_amount == {9'h000, $past(nominal_available_capacity[15:9])})
    else $error("step amount not capacity over 512");

  AST_FULL: assert property (@(posedge clk) disable iff (!rst_b)
    (charging && batt_mv >= term_mv && chg_sense_uv <= taper_uv) |=> full_charge)
    else $error("full charge not declared");

  AST_TERM_TOP: assert property (@(posedge clk) disable iff (!rst_b)
    (pack_b[6:5] == 2'b11) [*2] |-> term_mv == 13'd4112)
    else $error("termination code 11 not 4112 mV");

  AST_TERM_LOW: assert property (@(posedge clk) disable iff (!rst_b)
    (pack_b[6:5] == 2'b01) [*2] |-> term_mv == 13'd4016)
    else $error("termination code 01 not 4016 mV");

  AST_PIN_RESET_SET: assert property (@(posedge clk) disable iff (!rst_b)
    s_reset_release ##0 pack_b[`GCSD_PK_PIN_BIT] |=> pin_input_en)
    else $error("pin enable not set from stored setting");

  AST_PIN_RESET_CLR: assert property (@(posedge clk) disable iff (!rst_b)
    s_reset_release ##0 !pack_b[`GCSD_PK_PIN_BIT] |=> !pin_input_en)
    else $error("pin enable not cleared from stored setting");

  AST_PIN_FLAG: assert property (@(posedge clk) disable iff (!rst_b)
    pin_input_en && $past(pin_input_en) ##0 !$past(pin_s2_q) ##1 1'b1 |-> pin_level_flag_q == $past(pin_s2_q))
    else $error("pin level flag does not follow pin");

  AST_RATE_FIX: assert property (@(posedge clk) disable iff (!rst_b)
    fixed_rate_comp |=> rate_comp_constants == 8'h42)
    else $error("fixed rate compensation not 0x42");

  AST_TEMP_FIX: assert property (@(posedge clk) disable iff (!rst_b)
    fixed_temp_comp |=> temp_comp_constants == 8'h7c)
    else $error("fixed temperature compensation not 0x7c");

  AST_TEMP_NVM: assert property (@(posedge clk) disable iff (!rst_b)
    !fixed_temp_comp |=> temp_comp_constants == $past(nvm_q[`GCSD_TEMP_COMP_CONSTANTS_OFS]))
    else $error("stored temperature compensation not used");

  AST_WR_LOCK: assert property (@(posedge clk) disable iff (!rst_b)
    s_key_missing |=> nvm_q[$past(reg_addr)] == $past(nvm_q[reg_addr]))
    else $error("configuration byte written without enable key");
endmodule : gcsd_top

/* File: gcsd_regs.svh */
// Behaviour
// - filter byte: upper nibble activity threshold at 6 uV/count, lower nibble self-discharge code
// - self-discharge correction runs only while not charging
// - programmed rate used unchanged for 20 C <= temp < 30 C
// - rate doubles per 10 C band above, up to 16x at 60 C
// - rate halves per 10 C band below, down to 1/4 below 10 C
// - each step subtracts nominal capacity / 512; rate set by step spacing
// - full charge from battery voltage and charge current against taper * 192 uV
// - termination voltage from pack bits 6:5; bits 4:2 have no function
// - voltage codes 00..11 select 3968, 4016, 4064, 4112 mV
// - pin-input setting 0 clears live pin-input enable on reset
// - pin-input setting 1 sets live pin-input enable on reset
// - while pin is input, its level shows in a mode status bit
// - fixed rate bit set: use 0x42 instead of stored rate byte
// - fixed rate selected: location 0x7e is only an id byte
// - fixed temp bit set: use 0x7c instead of stored temp byte
// - fixed temp selected: location 0x7f is only an id byte
// - fixed temp bit clear: use stored temp compensation byte
`ifndef GCSD_REGS_SVH
`define GCSD_REGS_SVH
`define GCSD_MODE_OFS      7'h01
`define GCSD_MEMEN_OFS     7'h6e
`define GCSD_NVM_LO        7'h76
`define GCSD_NVM_HI        7'h7f
`define GCSD_FSD_OFS       7'h7a
`define GCSD_TAPER_OFS     7'h7b
`define GCSD_PACK_OFS      7'h7c
`define GCSD_RCOMP_OFS     7'h7e
`define GCSD_TEMP_COMP_CONSTANTS_OFS     7'h7f
`define GCSD_MEMEN_KEY     8'hdd
`define GCSD_FIX_RCOMP     8'h42
`define GCSD_FIX_TEMP_COMP_CONSTANTS     8'h7c
`define GCSD_PACK_MASK     8'he3
`define GCSD_PK_PIN_BIT    7
`define GCSD_PK_VHI_BIT    6
`define GCSD_PK_VLO_BIT    5
`define GCSD_PK_RFIX_BIT   1
`define GCSD_PK_TFIX_BIT   0
`define GCSD_MODE_EN_BIT   0
`define GCSD_MODE_LVL_BIT  1
`define GCSD_DMF_UV        16'd6
`define GCSD_TAPER_UV      16'd192
`define GCSD_VT0_MV        13'd3968
`define GCSD_VT1_MV        13'd4016
`define GCSD_VT2_MV        13'd4064
`define GCSD_VT3_MV        13'd4112
`define GCSD_CLK_HZ        20000000
`define GCSD_SD_UNIT_S     450
`define GCSD_SD_UNIT_CYC   (`GCSD_SD_UNIT_S * 64'd`GCSD_CLK_HZ)
`define GCSD_SD_REF_UNITS  7'd16
`define GCSD_T_BAND        8'sd10
`endif

/* File: gcsd_pkg.sv */
package gcsd_pkg;
  // log2 of step rate relative to quarter rate: 0 = 1/4x, 2 = 1x, 6 = 16x
  typedef logic [2:0] gcsd_scale_t;
  typedef enum logic {GCSD_HOLD, GCSD_COUNT} gcsd_st_t;
endpackage : gcsd_pkg

/* File: gcsd_sd_if.sv */
interface gcsd_sd_if;
  logic [3:0]          code;
  gcsd_pkg::gcsd_scale_t scale;
  logic                charging;
  logic                step;
  modport ctl (output code, output scale, output charging, input step);
  modport est (input code, input scale, input charging, output step);
endinterface : gcsd_sd_if

/* File: gcsd_sd_timer.sv */
`include "gcsd_regs.svh"
module gcsd_sd_timer #(
  parameter logic [35:0] UNIT_CYC = 36'(`GCSD_SD_UNIT_CYC)
) (
  input wire logic clk,
  input wire logic rst_b,
  gcsd_sd_if.est   sd
);
  gcsd_pkg::gcsd_st_t st_q;
  logic [35:0]        cyc_q;
  logic [9:0]         units_q;
  logic [9:0]         limit;
  logic               unit_tick;

  // 64 units is the quarter-rate spacing of one code step: code * 2 h * 4
  assign limit     = 10'(sd.code) * (10'd64 >> sd.scale);
  assign unit_tick = (st_q == gcsd_pkg::GCSD_COUNT) && (cyc_q == UNIT_CYC - 36'd1);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= gcsd_pkg::GCSD_HOLD;
    end else begin
      unique case (st_q)
        gcsd_pkg::GCSD_HOLD: if (!sd.charging && sd.code != 4'h0) st_q <= gcsd_pkg::GCSD_COUNT;
        gcsd_pkg::GCSD_COUNT: if (sd.charging || sd.code == 4'h0) st_q <= gcsd_pkg::GCSD_HOLD;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cyc_q <= 36'h0;
    end else if (st_q != gcsd_pkg::GCSD_COUNT || unit_tick) begin
      cyc_q <= 36'h0;
    end else begin
      cyc_q <= cyc_q + 36'd1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      units_q <= 10'h0;
      sd.step <= 1'b0;
    end else begin
      sd.step <= 1'b0;
      if (unit_tick) begin
        if (units_q + 10'd1 >= limit) begin
          units_q <= 10'h0;
          sd.step <= !sd.charging;
        end else begin
          units_q <= units_q + 10'd1;
        end
      end
    end
  end

  AST_STEP_NOT_CHG: assert property (@(posedge clk) disable iff (!rst_b)
    sd.step |-> !$past(sd.charging))
    else $error("self-discharge step while charging");
endmodule : gcsd_sd_timer

/* File: gcsd_host_model.sv */
`include "gcsd_regs.svh"
module gcsd_host_model (
  input  wire logic       clk,
  output logic      [6:0] reg_addr,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic      [7:0] reg_wdata,
  input  wire logic [7:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    reg_addr  = 7'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_wdata = 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////////
  // one-cycle byte write; data inverted once released so stale values show
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(negedge clk);
    reg_wr    = 1'b0;
    reg_wdata = ~d;
  endtask : wr

  // answer is taken one and a half cycles after the edge that samples the strobe
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_rd   = 1'b1;
    @(negedge clk);
    reg_rd   = 1'b0;
    @(negedge clk);
    d = reg_rdata;
  endtask : rd

  // configuration writes are locked until the key lands
  task automatic unlock();
    wr(`GCSD_MEMEN_OFS, `GCSD_MEMEN_KEY);
  endtask : unlock
endmodule : gcsd_host_model

/* File: tb_top.sv */
`include "gcsd_regs.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;

  localparam logic [35:0] UNIT = 36'h4;

  logic              clk;
  logic              rst_b;
  logic [6:0]        reg_addr;
  logic              reg_wr;
  logic              reg_rd;
  logic [7:0]        reg_wdata;
  logic [7:0]        reg_rdata;
  logic              gpio_pin;
  logic              charging;
  logic signed [7:0] temp_c;
  logic [12:0]       batt_mv;
  logic [15:0]       chg_sense_uv;
  logic [15:0]       nominal_available_capacity;
  logic [15:0]       activity_filter_uv;
  logic [12:0]       term_mv;
  logic              full_charge;
  logic [7:0]        rate_comp_constants;
  logic [7:0]        temp_comp_constants;
  logic              pin_input_en;
  logic              sd_step;
  logic [15:0]       sd_amount;
  int                failures;
  int                checked;
  int                cycles;

  gcsd_top #(.SD_UNIT_CYC(UNIT)) dut (
    .clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .gpio_pin(gpio_pin), .charging(charging),
    .temp_c(temp_c), .batt_mv(batt_mv), .chg_sense_uv(chg_sense_uv), .nominal_available_capacity(nominal_available_capacity),
    .activity_filter_uv(activity_filter_uv), .term_mv(term_mv), .full_charge(full_charge),
    .rate_comp_constants(rate_comp_constants), .temp_comp_constants(temp_comp_constants),
    .pin_input_en(pin_input_en), .sd_step(sd_step), .sd_amount(sd_amount)
  );

  gcsd_host_model host (
    .clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: seen 0x%0h expected 0x%0h", $time, seen, exp);
    end
  endtask : check

  task automatic final_report();
    $display("comparisons %0d, mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : final_report

  task automatic do_reset();
    @(negedge clk);
    rst_b = 1'b0;
    repeat (6) @(negedge clk);
    rst_b = 1'b1;
    @(negedge clk);
  endtask : do_reset

  // config outputs follow a stored byte one edge later
  task automatic settle();
    repeat (3) @(negedge clk);
  endtask : settle

  // counts cycles until the next step pulse; flags a miss at the limit
  task automatic wait_step(input int lim, output int n);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (sd_step !== 1'b1 && n < lim);
    check(n < lim, 1'b1);
  endtask : wait_step

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    logic [7:0]  d;
    logic [12:0] vt [4];
    vt = '{`GCSD_VT0_MV, `GCSD_VT1_MV, `GCSD_VT2_MV, `GCSD_VT3_MV};
    host.unlock();
    host.wr(`GCSD_FSD_OFS, 8'ha1);
    host.wr(`GCSD_TAPER_OFS, 8'h02);
    host.wr(`GCSD_PACK_OFS, 8'hff);
    settle();
    host.rd(`GCSD_FSD_OFS, d);
    check(d, 8'ha1);
    check(activity_filter_uv, 16'h003c);
    host.rd(`GCSD_PACK_OFS, d);
    check(d, 8'he3);
    check(rate_comp_constants, 8'h42);
    check(temp_comp_constants, 8'h7c);
    host.wr(`GCSD_RCOMP_OFS, 8'h55);
    host.wr(`GCSD_TEMP_COMP_CONSTANTS_OFS, 8'h66);
    settle();
    check(rate_comp_constants, 8'h42);
    check(temp_comp_constants, 8'h7c);
    host.rd(`GCSD_RCOMP_OFS, d);
    check(d, 8'h55);
    for (int v = 0; v < 4; v++) begin
      host.wr(`GCSD_PACK_OFS, {1'b0, 2'(v), 5'h00});
      settle();
      check(term_mv, vt[v]);
      check(rate_comp_constants, 8'h55);
      check(temp_comp_constants, 8'h66);
    end
    host.rd(7'h20, d);
    check(d, 8'h00);
  endtask : t_regs

  task automatic t_lock();
    logic [7:0] d;
    do_reset();
    host.wr(`GCSD_FSD_OFS, 8'h33);
    settle();
    host.rd(`GCSD_FSD_OFS, d);
    check(d, 8'ha1);
  endtask : t_lock

  task automatic t_pin();
    logic [7:0] d;
    host.unlock();
    host.wr(`GCSD_PACK_OFS, 8'h80);
    do_reset();
    check(pin_input_en, 1'b1);
    gpio_pin = 1'b1;
    repeat (4) @(negedge clk);
    host.rd(`GCSD_MODE_OFS, d);
    check(d[`GCSD_MODE_LVL_BIT], 1'b1);
    gpio_pin = 1'b0;
    repeat (4) @(negedge clk);
    host.rd(`GCSD_MODE_OFS, d);
    check(d[`GCSD_MODE_LVL_BIT], 1'b0);
    host.unlock();
    host.wr(`GCSD_PACK_OFS, 8'h60);
    do_reset();
    check(pin_input_en, 1'b0);
  endtask : t_pin

  // taper 2 gives a 384 uV limit, termination at 4112 mV
  task automatic t_full();
    charging     = 1'b1;
    batt_mv      = 13'd4112;
    chg_sense_uv = 16'd384;
    settle();
    check(full_charge, 1'b1);
    chg_sense_uv = 16'd385;
    settle();
    check(full_charge, 1'b0);
    chg_sense_uv = 16'd384;
    batt_mv      = 13'd4111;
    settle();
    check(full_charge, 1'b0);
  endtask : t_full

  task automatic t_sd();
    int n;
    int cnt;
    logic signed [7:0] tc [8];
    int un [8];
    tc = '{-8'sd5, 8'sd5, 8'sd15, 8'sd25, 8'sd35, 8'sd45, 8'sd55, 8'sd65};
    un = '{64, 64, 32, 16, 8, 4, 2, 1};
    host.unlock();
    host.wr(`GCSD_FSD_OFS, 8'h01);
    nominal_available_capacity      = 16'h1234;
    charging = 1'b0;
    for (int i = 0; i < 8; i++) begin
      temp_c = tc[i];
      wait_step(700, n);
      wait_step(700, n);
      check(n >= un[i] * 4 && n <= un[i] * 4 + 3, 1'b1);
      check(sd_amount, 16'h0009);
    end
    charging = 1'b1;
    cnt = 0;
    repeat (100) begin
      @(negedge clk);
      if (sd_step !== 1'b0) cnt++;
    end
    check(cnt, 0);
    charging = 1'b0;
    wait_step(20, n);
  endtask : t_sd

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      failures++;
      final_report();
    end
  end

  initial begin
    failures     = 0;
    checked      = 0;
    cycles       = 0;
    rst_b        = 1'b0;
    gpio_pin     = 1'b0;
    charging     = 1'b0;
    temp_c       = 8'sd25;
    batt_mv      = 13'd0;
    chg_sense_uv = 16'd0;
    nominal_available_capacity          = 16'h1234;
    repeat (6) @(negedge clk);
    rst_b = 1'b1;
    @(negedge clk);
    t_regs();
    t_lock();
    t_pin();
    host.unlock();
    t_full();
    t_sd();
    final_report();
  end
endmodule : tb_top
